// file: hdl/ccr_pkg.sv
package ccr_pkg;

  // register offsets
  localparam logic [7:0] STEP_DOWN_TWO_CONTROL_ADDR = 8'h06;
  localparam logic [7:0] BUCK_BOOST_CONTROL_ADDR = 8'h07;

  // field layout, both control bytes
  localparam int CODE_LSB = 0;
  localparam int CODE_W = 5;
  localparam int RESERVED_BIT = 7;
  localparam int SD2_FORCE_PWM_BIT = 5;
  localparam int SD2_ENABLE_BIT = 6;
  localparam int BB_ENABLE_BIT = 5;
  localparam int BB_FORCE_PWM_BIT = 6;

  // reset values of the single-bit fields
  localparam logic SD2_ENABLE_RESET = 1'h1;
  localparam logic SD2_FORCE_PWM_RESET = 1'h0;
  localparam logic BB_ENABLE_RESET = 1'h1;
  localparam logic BB_FORCE_PWM_RESET = 1'h0;
  // code held until the stored configuration arrives
  localparam logic [4:0] CODE_PRELOAD = 5'h00;

  // special codes
  localparam logic [4:0] CODE_OFF = 5'h00;
  localparam logic [4:0] CODE_FIRST = 5'h01;
  localparam logic [4:0] SD2_CODE_TOP = 5'h0F;

  // output voltage table in millivolts
  localparam logic [11:0] MV_BASE = 12'h708;
  localparam logic [11:0] MV_MAX = 12'hCE4;
  localparam logic [11:0] MV_NONE = 12'h000;
  localparam logic [11:0] SD2_MV_STEP = 12'h064;
  localparam logic [11:0] BB_MV_STEP = 12'h032;

  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // power-on sequencing progress
  typedef enum logic [3:0] {
    CCR_SEQ_WAIT_CFG = 4'h1,
    CCR_SEQ_WAIT_SD2 = 4'h2,
    CCR_SEQ_WAIT_BB = 4'h4,
    CCR_SEQ_DONE = 4'h8
  } ccr_seq_t;

endpackage

// file: hdl/ccr_converter_control_regs.sv
// How it works
// - step-down-two byte at 0x06, bit7 reads zero
// - step-down-two code: 1.80V+0.10V steps, 0x1x=3.30V, 0=external
// - step-down-two bit5 forces fixed-frequency, resets zero
// - step-down-two on at sequencing; bit6 enables it
// - buck-boost byte at 0x07, bit7 reads zero
// - buck-boost turned on by power-on sequencing
// - buck-boost code zero keeps it disabled
// - pull-down on while disabled, off at code zero
// - buck-boost code reset from stored configuration
// - buck-boost code: 1.80V+0.05V steps to 3.30V
// - buck-boost bit6 forces fixed-frequency, resets zero
`timescale 1ns/1ns
`default_nettype none

module ccr_converter_control_regs #(
  parameter int CODE_W = 5
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic cfg_load,
  input wire logic [CODE_W-1:0] cfg_step_down_two_code,
  input wire logic [CODE_W-1:0] cfg_buck_boost_code,
  input wire logic seq_step,
  output logic seq_done,
  output logic step_down_two_on,
  output logic step_down_two_ext_ctrl,
  output logic step_down_two_force_pwm,
  output logic [11:0] step_down_two_mv,
  output logic buck_boost_on,
  output logic buck_boost_force_pwm,
  output logic buck_boost_pulldown,
  output logic [11:0] buck_boost_mv
);

  if (CODE_W != ccr_pkg::CODE_W) begin : g_bad_width
    $error("code width must be 5");
  end
  // code field must stay clear of the flag bits
  if (ccr_pkg::CODE_LSB + CODE_W > ccr_pkg::SD2_FORCE_PWM_BIT) begin : g_bad_sd2_layout
    $error("step-down-two code field overlaps its flag bits");
  end
  if (ccr_pkg::CODE_LSB + CODE_W > ccr_pkg::BB_ENABLE_BIT) begin : g_bad_bb_layout
    $error("buck-boost code field overlaps its flag bits");
  end

  logic [CODE_W-1:0] sd2_code;
  logic sd2_force_pwm;
  logic sd2_enable;
  logic [CODE_W-1:0] bb_code;
  logic bb_force_pwm;
  logic bb_enable;
  ccr_pkg::ccr_seq_t seq_state;
  ccr_pkg::ccr_seq_t next_seq_state;
  logic sd2_seq_reached;
  logic bb_seq_reached;
  logic cfg_take;
  logic wr_sd2;
  logic wr_bb;
  logic [7:0] sd2_byte;
  logic [7:0] bb_byte;
  logic next_sd2_on;
  logic next_bb_on;
  logic [11:0] next_sd2_mv;
  logic [11:0] next_bb_mv;

  assign wr_sd2 = reg_wr && (reg_addr == ccr_pkg::STEP_DOWN_TWO_CONTROL_ADDR);
  assign wr_bb = reg_wr && (reg_addr == ccr_pkg::BUCK_BOOST_CONTROL_ADDR);

  // stored codes land only while waiting for them
  assign cfg_take = cfg_load && (seq_state == ccr_pkg::CCR_SEQ_WAIT_CFG);

  // power-on sequencing: config load, then step-down-two, then buck-boost
  always_comb begin
    next_seq_state = seq_state;
    case (seq_state)
      ccr_pkg::CCR_SEQ_WAIT_CFG: begin
        if (cfg_load) begin
          next_seq_state = ccr_pkg::CCR_SEQ_WAIT_SD2;
        end
      end
      ccr_pkg::CCR_SEQ_WAIT_SD2: begin
        if (seq_step) begin
          next_seq_state = ccr_pkg::CCR_SEQ_WAIT_BB;
        end
      end
      ccr_pkg::CCR_SEQ_WAIT_BB: begin
        if (seq_step) begin
          next_seq_state = ccr_pkg::CCR_SEQ_DONE;
        end
      end
      ccr_pkg::CCR_SEQ_DONE: begin
        next_seq_state = ccr_pkg::CCR_SEQ_DONE;
      end
      default: begin
        next_seq_state = ccr_pkg::CCR_SEQ_WAIT_CFG;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      seq_state <= ccr_pkg::CCR_SEQ_WAIT_CFG;
    end else begin
      seq_state <= next_seq_state;
    end
  end

  assign sd2_seq_reached = (seq_state == ccr_pkg::CCR_SEQ_WAIT_BB) || (seq_state == ccr_pkg::CCR_SEQ_DONE);
  assign bb_seq_reached = (seq_state == ccr_pkg::CCR_SEQ_DONE);

  // status level from a flop, tracks the state register exactly
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      seq_done <= 1'b0;
    end else begin
      seq_done <= (next_seq_state == ccr_pkg::CCR_SEQ_DONE);
    end
  end

  // step-down-two control byte
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sd2_code <= CODE_W'(ccr_pkg::CODE_PRELOAD);
      sd2_force_pwm <= ccr_pkg::SD2_FORCE_PWM_RESET;
      sd2_enable <= ccr_pkg::SD2_ENABLE_RESET;
    end else if (wr_sd2) begin
      sd2_code <= reg_wdata[ccr_pkg::CODE_LSB +: CODE_W];
      sd2_force_pwm <= reg_wdata[ccr_pkg::SD2_FORCE_PWM_BIT];
      sd2_enable <= reg_wdata[ccr_pkg::SD2_ENABLE_BIT];
    // host write wins over a same-cycle load
    end else if (cfg_take) begin
      sd2_code <= cfg_step_down_two_code;
    end
  end

  // buck-boost control byte
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      bb_code <= CODE_W'(ccr_pkg::CODE_PRELOAD);
      bb_force_pwm <= ccr_pkg::BB_FORCE_PWM_RESET;
      bb_enable <= ccr_pkg::BB_ENABLE_RESET;
    end else if (wr_bb) begin
      bb_code <= reg_wdata[ccr_pkg::CODE_LSB +: CODE_W];
      bb_force_pwm <= reg_wdata[ccr_pkg::BB_FORCE_PWM_BIT];
      bb_enable <= reg_wdata[ccr_pkg::BB_ENABLE_BIT];
    // host write wins over a same-cycle load
    end else if (cfg_take) begin
      bb_code <= cfg_buck_boost_code;
    end
  end

  // read-back images, reserved bit fixed low
  always_comb begin
    sd2_byte = 8'h00;
    sd2_byte[ccr_pkg::CODE_LSB +: CODE_W] = sd2_code;
    sd2_byte[ccr_pkg::SD2_FORCE_PWM_BIT] = sd2_force_pwm;
    sd2_byte[ccr_pkg::SD2_ENABLE_BIT] = sd2_enable;
    sd2_byte[ccr_pkg::RESERVED_BIT] = 1'b0;
    bb_byte = 8'h00;
    bb_byte[ccr_pkg::CODE_LSB +: CODE_W] = bb_code;
    bb_byte[ccr_pkg::BB_ENABLE_BIT] = bb_enable;
    bb_byte[ccr_pkg::BB_FORCE_PWM_BIT] = bb_force_pwm;
    bb_byte[ccr_pkg::RESERVED_BIT] = 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reg_rdata <= ccr_pkg::READ_UNMAPPED;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (reg_addr == ccr_pkg::STEP_DOWN_TWO_CONTROL_ADDR) begin
          reg_rdata <= sd2_byte;
        end else if (reg_addr == ccr_pkg::BUCK_BOOST_CONTROL_ADDR) begin
          reg_rdata <= bb_byte;
        end else begin
          reg_rdata <= ccr_pkg::READ_UNMAPPED;
        end
      end
    end
  end

  // converter enables and voltage decode
  always_comb begin
    next_sd2_on = sd2_seq_reached && sd2_enable;
    next_bb_on = bb_seq_reached && bb_enable && (bb_code != CODE_W'(ccr_pkg::CODE_OFF));
  end

  ccr_mv_decode #(
    .CODE_W(CODE_W),
    .STEP_MV(ccr_pkg::SD2_MV_STEP),
    .TOP_CODE(CODE_W'(ccr_pkg::SD2_CODE_TOP))
  ) ccr_mv_decode_sd2_i (
    .code(sd2_code),
    .mv(next_sd2_mv)
  );

  ccr_mv_decode #(
    .CODE_W(CODE_W),
    .STEP_MV(ccr_pkg::BB_MV_STEP),
    .TOP_CODE('1)
  ) ccr_mv_decode_bb_i (
    .code(bb_code),
    .mv(next_bb_mv)
  );

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      step_down_two_on <= 1'b0;
      step_down_two_ext_ctrl <= 1'b0;
      step_down_two_force_pwm <= 1'b0;
      step_down_two_mv <= ccr_pkg::MV_NONE;
    end else begin
      step_down_two_on <= next_sd2_on;
      step_down_two_ext_ctrl <= (sd2_code == CODE_W'(ccr_pkg::CODE_OFF));
      step_down_two_force_pwm <= sd2_force_pwm;
      step_down_two_mv <= next_sd2_mv;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      buck_boost_on <= 1'b0;
      buck_boost_force_pwm <= 1'b0;
      buck_boost_pulldown <= 1'b0;
      buck_boost_mv <= ccr_pkg::MV_NONE;
    end else begin
      buck_boost_on <= next_bb_on;
      buck_boost_force_pwm <= bb_force_pwm;
      // pull-down while off, released at code zero
      buck_boost_pulldown <= !next_bb_on && (bb_code != CODE_W'(ccr_pkg::CODE_OFF));
      buck_boost_mv <= next_bb_mv;
    end
  end

endmodule

// code to millivolts: zero gives no target, codes above the top clamp
module ccr_mv_decode #(
  parameter int CODE_W = 5,
  parameter logic [11:0] STEP_MV = ccr_pkg::SD2_MV_STEP,
  parameter logic [CODE_W-1:0] TOP_CODE = CODE_W'(ccr_pkg::SD2_CODE_TOP)
) (
  input wire logic [CODE_W-1:0] code,
  output logic [11:0] mv
);

  logic [CODE_W-1:0] step_index;
  logic [11:0] step_total;

  if (CODE_W != ccr_pkg::CODE_W) begin : g_bad_width
    $error("code width must be 5");
  end

  // codes count from one, so the first code adds no step
  assign step_index = code - CODE_W'(ccr_pkg::CODE_FIRST);
  assign step_total = 12'(STEP_MV * 12'(step_index));

  always_comb begin
    if (code == CODE_W'(ccr_pkg::CODE_OFF)) begin
      mv = ccr_pkg::MV_NONE;
    end else if (code > TOP_CODE) begin
      mv = ccr_pkg::MV_MAX;
    end else begin
      mv = 12'(ccr_pkg::MV_BASE + step_total);
    end
  end

endmodule

`default_nettype wire

// file: sim/ccr_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module ccr_monitor (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic step_down_two_ext_ctrl,
  input wire logic [11:0] step_down_two_mv,
  input wire logic buck_boost_on,
  input wire logic buck_boost_force_pwm,
  input wire logic buck_boost_pulldown,
  input wire logic [11:0] buck_boost_mv
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  a_rd_answer: assert property (reg_rvalid == $past(reg_rd))
    else $error("read answer late or spurious");
  a_rsvd_zero: assert property (reg_rvalid |-> !reg_rdata[7])
    else $error("reserved bit read as one");
  a_bb_code_off: assert property (buck_boost_mv == 12'h000 |-> !buck_boost_on)
    else $error("buck-boost on with code zero");
  a_pulldown_link: assert property (buck_boost_pulldown == (!buck_boost_on && buck_boost_mv != 12'h000))
    else $error("pull-down control wrong");
  a_sd2_ext: assert property ($past(resetn) |-> step_down_two_ext_ctrl == (step_down_two_mv == 12'h000))
    else $error("external control flag wrong");
  a_bb_mv_grid: assert property ((buck_boost_mv != 12'h000) |-> (buck_boost_mv >= 12'h708) &&
      (buck_boost_mv <= 12'hCE4) && (buck_boost_mv % 12'h032 == 12'h000)) else $error("buck-boost mV off grid");
  a_bb_pwm_wr: assert property ((reg_wr && reg_addr == 8'h07) ##1 !reg_wr |=>
      buck_boost_force_pwm == $past(reg_wdata[6], 2)) else $error("buck-boost pwm bit not applied");
  a_bb_en_wr: assert property ((reg_wr && reg_addr == 8'h07 && !reg_wdata[5]) ##1 !reg_wr |=>
      !buck_boost_on) else $error("buck-boost on with enable clear");
endmodule
bind ccr_converter_control_regs ccr_monitor ccr_monitor_i (.*);
`default_nettype wire

// file: sim/ccr_host.sv
`timescale 1ns/1ns
`default_nettype none
module ccr_host (
  input wire logic ref_clk,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk) #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk) #1;
    reg_rd = 1'b0;
    d = reg_rvalid ? reg_rdata : 8'hFF;
  endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic cfg_load = 1'b0;
  logic seq_step = 1'b0;
  logic [4:0] cfg_step_down_two_code = 5'h00;
  logic [4:0] cfg_buck_boost_code = 5'h00;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, q;
  logic reg_wr, reg_rd, reg_rvalid, seq_done, step_down_two_on, step_down_two_ext_ctrl;
  logic step_down_two_force_pwm, buck_boost_on, buck_boost_force_pwm, buck_boost_pulldown;
  logic [11:0] step_down_two_mv, buck_boost_mv;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 63;
  int sd2, bb, seq;
  logic [7:0] tbl [6] = '{8'hFF, 8'h20, 8'h21, 8'h6F, 8'h50, 8'h1F};
  ccr_converter_control_regs ccr_converter_control_regs_i (.*);
  ccr_host ccr_host_i (.*);
  always #25 ref_clk = ~ref_clk;
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up;
    end
  end
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
    n_tests++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask
  task automatic tick;
    @(posedge ref_clk) #1;
  endtask
  task automatic rchk(input logic [7:0] a, input int e);
    ccr_host_i.rd(a, q);
    chk("rdata", e, q);
  endtask
  task automatic outs;
    int c, b;
    c = sd2 % 32;
    b = bb % 32;
    chk("sd2_on", seq > 0 && sd2[6], step_down_two_on);
    chk("sd2_ext", c == 0, step_down_two_ext_ctrl);
    chk("sd2_mv", c == 0 ? 0 : c > 15 ? 3300 : 1700 + 100 * c, step_down_two_mv);
    chk("sd2_pwm", sd2[5], step_down_two_force_pwm);
    chk("seq_done", seq > 1, seq_done);
    chk("bb_on", seq > 1 && bb[5] && b != 0, buck_boost_on);
    chk("bb_pd", !(seq > 1 && bb[5]) && b != 0, buck_boost_pulldown);
    chk("bb_mv", b == 0 ? 0 : 1750 + 50 * b, buck_boost_mv);
    chk("bb_pwm", bb[6], buck_boost_force_pwm);
  endtask
  initial begin
    repeat (5) tick;
    resetn = 1'b1;
    rchk(8'h06, 8'h40);
    rchk(8'h07, 8'h20);
    seq_step = 1'b1;
    tick;
    cfg_step_down_two_code = 5'($random(seed));
    cfg_buck_boost_code = 5'($random(seed));
    cfg_load = 1'b1;
    seq_step = 1'b0;
    tick;
    cfg_load = 1'b0;
    sd2 = 64 + cfg_step_down_two_code;
    bb = 32 + cfg_buck_boost_code;
    seq_step = 1'b1;
    tick;
    seq_step = 1'b0;
    tick;
    seq = 1;
    outs;
    seq_step = 1'b1;
    tick;
    seq_step = 1'b0;
    cfg_step_down_two_code = ~cfg_step_down_two_code;
    cfg_buck_boost_code = ~cfg_buck_boost_code;
    cfg_load = 1'b1;
    tick;
    cfg_load = 1'b0;
    seq = 2;
    outs;
    rchk(8'h07, bb);
    rchk(8'h06, sd2);
    for (int i = 0; i < 30; i++) begin
      d = i < 6 ? tbl[i] : 8'($random(seed));
      ccr_host_i.wr(8'h06, d);
      ccr_host_i.wr(8'h07, d & 8'hDF);
      ccr_host_i.wr(8'h07, d);
      ccr_host_i.wr(8'h08, ~d);
      sd2 = d % 128;
      bb = d % 128;
      tick;
      outs;
      rchk(8'h06, sd2);
      rchk(8'h07, bb);
      rchk(8'h08, 0);
    end
    resetn = 1'b0;
    tick;
    resetn = 1'b1;
    rchk(8'h07, 8'h20);
    rchk(8'h06, 8'h40);
    seq = 0;
    sd2 = 64;
    bb = 32;
    outs;
    wrap_up;
  end
endmodule
`default_nettype wire
